// ===== tb/fbm_flash_model.sv
// Purpose: Behavioural banked flash seen at the controller's pins
// Assumes: Command codes and busy times are plain defaults
// Notes:   Undriven data lines show the inverse of the last word
`timescale 1ns/100ps
module fbm_flash_model #(
  parameter int          BUSY_NS = 2000,
  parameter logic [15:0] ID_CODE = 16'h5a3c  // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        flash_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        wr_strobe_n,
  input  wire logic        hw_reset_n,
  input  wire logic [21:0] flash_addr,
  input  wire logic        width_select,
  input  wire logic [15:0] data_lines_out,
  output logic      [15:0] data_lines_in,
  output logic             ready_busy_out
);
  logic [15:0] mem [int];
  logic [15:0] last, val;
  logic        id_mode, prog_next, drive;
  int          gen;
  initial begin
    id_mode = 1'b0;
    prog_next = 1'b0;
    ready_busy_out = 1'b1;
    last = 16'h0;
    gen = 0;
  end
  // Reads answer at once after any idle time, data stays
  // Reads in any bank, also while busy
  assign drive = !flash_sel_n && !out_gate_n && wr_strobe_n && hw_reset_n;
  assign val = id_mode ? ID_CODE : (mem.exists(flash_addr) ?
               mem[flash_addr] : 16'hffff);
  assign data_lines_in = drive ? val : ~last;
  always @(posedge core_clk) if (drive) last <= val;
  // Command capture on strobe release; second cycle programs
  always @(posedge wr_strobe_n) begin
    if (!flash_sel_n && hw_reset_n) begin
      if (prog_next) begin
        prog_next = 1'b0;
        gen++;
        ready_busy_out = 1'b0;  // Runs on when deselected
        fork begin
          automatic int k = gen;
          automatic int a = flash_addr;
          automatic logic [15:0] d = width_select ? data_lines_out :
                                     {8'h00, data_lines_out[7:0]};
          #BUSY_NS;
          if (k == gen) begin
            mem[a] = d;
            ready_busy_out = 1'b1;
          end
        end join_none
      end else begin
        prog_next = data_lines_out == 16'h00a0;
        if (data_lines_out == 16'h0090) id_mode = 1'b1;
        if (data_lines_out == 16'h00f0) id_mode = 1'b0;
        if (data_lines_out == 16'h0030) begin
          // Erase the sector named by the upper address bits
          gen++;
          ready_busy_out = 1'b0;
          fork begin
            automatic int k = gen;
            automatic logic [9:0] s = flash_addr[21:12];
            automatic int keys [$];
            #BUSY_NS;
            if (k == gen) begin
              foreach (mem[i]) if (i[21:12] == s) keys.push_back(i);
              foreach (keys[j]) mem.delete(keys[j]);
              ready_busy_out = 1'b1;
            end
          end join_none
        end
      end
    end
  end
  // Reset pulse aborts work and returns to array read
  always @(negedge hw_reset_n) begin
    gen++;
    id_mode = 1'b0;
    prog_next = 1'b0;
    ready_busy_out = 1'b0;
    #300 ready_busy_out = 1'b1;
  end
endmodule

// ===== tb/fbm_host_ctrl_sva.sv
// Purpose: Pin protocol checks for the flash host controller
// Assumes: One clock domain, rst asynchronous active high
// Notes:   Sees only the top module's ports
`timescale 1ns/100ps
module fbm_host_ctrl_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flash_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic hw_reset_n,
  input wire logic protect_accel_pin,
  input wire logic data_lines_oe,
  input wire logic rsp_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Pin level pairs for reads and writes
  property p_read_pins;
    !out_gate_n |-> !flash_sel_n && wr_strobe_n;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("gate low without select or with strobe");
  property p_write_pins;
    !wr_strobe_n |-> !flash_sel_n && out_gate_n && data_lines_oe;
  endproperty
  a_write_pins: assert property (p_write_pins)
    else $error("strobe low with bad select, gate or drive");
  property p_strobe_width;
    $fell(wr_strobe_n) |=> wr_strobe_n;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("write strobe low longer than one cycle");
  property p_rsp_after_gate;
    rsp_valid |-> $past(out_gate_n) == 1'b0;
  endproperty
  a_rsp_after_gate: assert property (p_rsp_after_gate)
    else $error("read answer without gated read cycle");
  property p_accel_tied;
    protect_accel_pin;
  endproperty
  a_accel_tied: assert property (p_accel_tied)
    else $error("protect pin not held high");
  property p_release_wait;
    $rose(hw_reset_n) |-> out_gate_n [*2];
  endproperty
  a_release_wait: assert property (p_release_wait)
    else $error("read started too soon after reset release");
  property p_clear_width;
    $fell(hw_reset_n) |-> !hw_reset_n [*8] ##5 !hw_reset_n;
  endproperty
  a_clear_width: assert property (p_clear_width)
    else $error("device reset pulse too short");
  property p_quiet_in_reset;
    !hw_reset_n |-> flash_sel_n && wr_strobe_n;
  endproperty
  a_quiet_in_reset: assert property (p_quiet_in_reset)
    else $error("bus access during device reset");
endmodule
bind fbm_host_ctrl fbm_host_ctrl_sva chk_i (.*);

// ===== tb/fbm_host_ctrl_tb.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Inputs change at the falling clock edge
// Notes:   Read results go through an expectation queue
`timescale 1ns/100ps
module fbm_host_ctrl_tb;
  logic        core_clk, rst, clk_en, req_valid, req_ready, seq_load;
  logic        byte_mode, rsp_valid, rsp_err, dev_busy, flash_sel_n;
  logic        out_gate_n, wr_strobe_n, hw_reset_n, width_select;
  logic        protect_accel_pin, accel_high_en, data_lines_oe;
  logic        ready_busy_out, exp_err;
  logic [1:0]  req_op, seq_idx, rsp_bank;
  logic [2:0]  seq_len;
  logic [21:0] req_addr, seq_addr, flash_addr, a;
  logic [15:0] seq_data, rsp_data, data_lines_in, data_lines_out;
  logic [18:0] exp_q [$];
  logic [31:0] lf;
  int          n_errors, check_count, cyc;
  fbm_host_ctrl #(.READY_WAIT(20)) dut (.*);
  fbm_flash_model flash_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [18:0] e, input logic [18:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic settle;
    int n;
    n = 0;
    wait_idle;
    repeat (4) @(negedge core_clk);
    while (dev_busy !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic req(input logic [1:0] op, input logic [21:0] ad);
    @(negedge core_clk); // Let an edge pass after the last release
    wait_idle;
    req_valid = 1'b1;
    req_op = op;
    req_addr = ad;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic rd(input logic [21:0] ad, input logic [15:0] e);
    exp_q.push_back({exp_err, ad[21:20], e});
    req(2'd0, ad);
  endtask
  task automatic wr(input logic [21:0] ad, input logic [15:0] d0, d1,
                    input logic [2:0] n);
    wait_idle;
    seq_load = 1'b1;
    seq_idx = 2'd0;
    seq_addr = ad;
    seq_data = d0;
    @(negedge core_clk);
    seq_idx = 2'd1;
    seq_data = d1;
    @(negedge core_clk);
    seq_load = 1'b0;
    seq_len = n;
    req(2'd1, ad);
  endtask
  // Compare each read answer with the oldest expectation
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, 19'h0,
                 {rsp_err, rsp_bank, rsp_data});
      end else
        chk(exp_q.pop_front(), {rsp_err, rsp_bank, rsp_data});
    end
  end
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    {rst, clk_en} = 2'b11;
    {req_valid, seq_load, byte_mode, exp_err, req_op, seq_idx} = '0;
    {req_addr, seq_addr, seq_data, seq_len} = '0;
    {n_errors, check_count, cyc} = '0;
    lf = 32'h9b23;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    rd(22'h000040, 16'hffff);
    // A frozen read must still answer once, and only once
    rd(22'h000080, 16'hffff);
    clk_en = 1'b0;
    repeat (lf[2:0] + 2) @(negedge core_clk);
    clk_en = 1'b1;
    for (int b = 0; b < 4; b++) begin
      lf = lfsr(lf);
      a = {b[1:0], 20'h00100};
      wr(a, 16'h00a0, lf[15:0], 3'd2);
      exp_err = 1'b1; // Program still running in the other bank
      rd({~b[1:0], 20'h00200}, 16'hffff);
      exp_err = 1'b0;
      settle;
      rd(a, lf[15:0]);
    end
    wr(22'h0, 16'h0090, 16'h0, 3'd1);
    rd(22'h000010, 16'h5a3c);
    wr(22'h0, 16'h00f0, 16'h0, 3'd1);
    rd(22'h000010, 16'hffff);
    lf = lfsr(lf);
    byte_mode = 1'b1;
    wr(22'h000300, 16'h00a0, lf[15:0], 3'd2);
    settle;
    byte_mode = 1'b0;
    rd(22'h000300, {8'h00, lf[7:0]});
    // Erase sector 0 only; sector 1 keeps its word
    wr(22'h001000, 16'h00a0, 16'h1234, 3'd2);
    settle;
    wr(22'h000000, 16'h0030, 16'h0000, 3'd1);
    exp_err = 1'b1; // Erase still running
    rd(22'h001000, 16'h1234);
    exp_err = 1'b0;
    settle;
    rd(22'h000300, 16'hffff);
    rd(22'h001000, 16'h1234);
    wr(22'h000400, 16'h00a0, 16'h1234, 3'd2);
    req(2'd2, 22'h0);
    settle;
    rd(22'h000400, 16'hffff);
    req(2'd3, 22'h1);
    wait_idle;
    chk(19'h1, {18'h0, accel_high_en});
    req(2'd3, 22'h0);
    wait_idle;
    chk(19'h0, {18'h0, accel_high_en});
    repeat (20) @(negedge core_clk);
    chk(19'h0, 19'(exp_q.size()));
    test_done;
  end
endmodule

// ===== verilog/fbm_host_ctrl.sv
// Purpose: Host controller driving a banked parallel NOR flash by its pins
// Assumes: Flash has no clock; pins sampled here are synchronised
// Notes:   A write request plays a loaded sequence of 1..4 pairs
`timescale 1ns/100ps
module fbm_host_ctrl #(
  parameter int READY_WAIT = fbm_pkg::READY_CYC,
  parameter int SEQ_DEPTH  = fbm_pkg::UNLOCK_LEN
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        clk_en,
  // User side
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic [1:0]                  req_op,
  input  wire logic [fbm_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic                        seq_load,
  input  wire logic [$clog2(SEQ_DEPTH)-1:0] seq_idx,
  input  wire logic [fbm_pkg::ADDR_W-1:0]  seq_addr,
  input  wire logic [fbm_pkg::DATA_W-1:0]  seq_data,
  input  wire logic [$clog2(SEQ_DEPTH):0]  seq_len,
  input  wire logic                        byte_mode,
  output logic                             rsp_valid,
  output logic      [fbm_pkg::DATA_W-1:0]  rsp_data,
  output logic                             rsp_err,
  output logic                             dev_busy,
  output logic      [fbm_pkg::BANK_W-1:0]  rsp_bank,
  // Flash pins
  output logic                             flash_sel_n,
  output logic                             out_gate_n,
  output logic                             wr_strobe_n,
  output logic                             hw_reset_n,
  output logic      [fbm_pkg::ADDR_W-1:0]  flash_addr,
  output logic                             width_select,
  output logic                             protect_accel_pin,
  output logic                             accel_high_en,
  input  wire logic [fbm_pkg::DATA_W-1:0]  data_lines_in,
  output logic      [fbm_pkg::DATA_W-1:0]  data_lines_out,
  output logic                             data_lines_oe,
  input  wire logic                        ready_busy_out
);
  localparam int PAIR_W = fbm_pkg::ADDR_W + fbm_pkg::DATA_W;
  localparam int IDX_W  = $clog2(SEQ_DEPTH);

  typedef enum logic [3:0] {
    FBM_IDLE, FBM_RD_WAIT, FBM_RD_TAKE, FBM_WR_SETUP, FBM_WR_PULSE,
    FBM_WR_GAP, FBM_RST_PULSE, FBM_RST_READY, FBM_RST_HOLD
  } fbm_state_e;

  fbm_state_e                  state_r;
  logic [fbm_pkg::CNT_W-1:0]   cnt_r;
  logic [IDX_W-1:0]            step_r;
  logic [IDX_W:0]              len_r;
  logic [PAIR_W-1:0]           pair_rd;
  logic [IDX_W-1:0]            rd_step;
  logic [1:0]                  rb_sync_r;
  logic [fbm_pkg::DATA_W-1:0]  din_meta_r;
  logic [fbm_pkg::DATA_W-1:0]  din_sync_r;
  logic                        accel_r;

  // Bank number from an address
  function automatic logic [fbm_pkg::BANK_W-1:0] bank_of(
    input logic [fbm_pkg::ADDR_W-1:0] a);
    bank_of = a[fbm_pkg::BANK_LSB +: fbm_pkg::BANK_W];
  endfunction

  // Read one pair ahead during the gap, so the next setup cycle already
  // shows the new pair instead of the one just written
  assign rd_step = (state_r == FBM_WR_GAP) ? step_r + 1'b1 : step_r;

  // Sequence storage; an erase of one or many sectors or the chip is
  // just a different list of pairs, each sector pair with its own bits
  fbm_seq_mem #(.WIDTH(PAIR_W), .DEPTH(SEQ_DEPTH)) u_seq (
    .core_clk (core_clk),
    .clk_en   (clk_en),
    .wr_en    (seq_load),
    .wr_idx   (seq_idx),
    .wr_data  ({seq_addr, seq_data}),
    .rd_idx   (rd_step),
    .rd_data  (pair_rd)
  );

  // Two-stage synchronisers for pins from the flash
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rb_sync_r  <= 2'h0;
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else if (clk_en) begin
      rb_sync_r  <= {rb_sync_r[0], ready_busy_out};
      din_meta_r <= data_lines_in;
      din_sync_r <= din_meta_r;
    end
  end

  assign dev_busy  = ~rb_sync_r[1]; // Busy shown while device runs
  assign req_ready = (state_r == FBM_IDLE);

  // Main bus sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= FBM_RST_PULSE;  // Reset the flash to array read
      cnt_r   <= '0;
      step_r  <= '0;
      len_r   <= '0;
    end else if (clk_en) begin
      case (state_r)
        FBM_IDLE: begin
          cnt_r  <= '0;
          step_r <= '0;
          if (req_valid) begin
            case (fbm_pkg::fbm_op_e'(req_op))
              // Reads need no command; allowed in any bank while busy
              fbm_pkg::FBM_OP_READ:  state_r <= FBM_RD_WAIT;
              fbm_pkg::FBM_OP_WRITE: begin
                len_r   <= seq_len;  // Two pairs in short mode
                state_r <= FBM_WR_SETUP;
              end
              fbm_pkg::FBM_OP_RESET: state_r <= FBM_RST_PULSE;
              default:               state_r <= FBM_IDLE;
            endcase
          end
        end
        FBM_RD_WAIT: begin
          // Hold address for access time plus synchroniser delay
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == fbm_pkg::CNT_W'(fbm_pkg::ACCESS_CYC + 1)) begin
            state_r <= FBM_RD_TAKE;
          end
        end
        FBM_RD_TAKE:  state_r <= FBM_IDLE;
        FBM_WR_SETUP: begin
          cnt_r   <= '0;
          state_r <= FBM_WR_PULSE;
        end
        FBM_WR_PULSE: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == fbm_pkg::CNT_W'(fbm_pkg::WRITE_CYC - 1)) begin
            state_r <= FBM_WR_GAP;
          end
        end
        FBM_WR_GAP: begin
          if ({1'b0, step_r} + 1'b1 >= len_r) begin
            state_r <= FBM_IDLE;
          end else begin
            step_r  <= step_r + 1'b1;
            state_r <= FBM_WR_SETUP;
          end
        end
        FBM_RST_PULSE: begin
          // Hold the clear pin low for the least pulse width
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == fbm_pkg::CNT_W'(fbm_pkg::CLEAR_CYC - 1)) begin
            cnt_r   <= '0;
            state_r <= FBM_RST_READY;
          end
        end
        FBM_RST_READY: begin
          // Wait for ready, bounded by the recovery time
          cnt_r <= cnt_r + 1'b1;
          if (rb_sync_r[1] ||
              cnt_r == fbm_pkg::CNT_W'(READY_WAIT)) begin
            cnt_r   <= '0;
            state_r <= FBM_RST_HOLD;
          end
        end
        FBM_RST_HOLD: begin
          // No read before the release time has passed
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == fbm_pkg::CNT_W'(fbm_pkg::RELEASE_CYC - 1)) begin
            state_r <= FBM_IDLE; // User reissues aborted work
          end
        end
        default: state_r <= FBM_IDLE;
      endcase
    end
  end

  // Accelerate level, set or cleared by an accel request and cleared by a device reset pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      accel_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == FBM_IDLE && req_valid &&
          req_op == 2'(fbm_pkg::FBM_OP_ACCEL)) begin
        accel_r <= req_addr[0]; // Enter or leave accel mode
      end else if (state_r == FBM_RST_PULSE) begin
        accel_r <= 1'b0;
      end
    end
  end

  // Pin drive: protect pin is always driven, never floating
  assign protect_accel_pin = 1'b1;
  assign accel_high_en     = accel_r;
  assign width_select      = ~byte_mode; // Word when high

  // Registered pin outputs and read answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_sel_n    <= 1'b1;
      out_gate_n     <= 1'b1;
      wr_strobe_n    <= 1'b1;
      hw_reset_n     <= 1'b0;
      flash_addr     <= '0;
      data_lines_out <= '0;
      data_lines_oe  <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_data       <= '0;
      rsp_err        <= 1'b0;
      rsp_bank       <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      hw_reset_n <= (state_r != FBM_RST_PULSE);
      // Idle: select and reset high give standby
      flash_sel_n   <= 1'b1;
      out_gate_n    <= 1'b1;
      wr_strobe_n   <= 1'b1;
      data_lines_oe <= 1'b0;
      case (state_r)
        FBM_IDLE: begin
          if (req_valid && req_op == 2'(fbm_pkg::FBM_OP_READ)) begin
            flash_addr  <= req_addr;
            flash_sel_n <= 1'b0; // Read cycle, strobe stays high
            out_gate_n  <= 1'b0;
          end
        end
        FBM_RD_WAIT: begin
          flash_sel_n <= 1'b0;
          out_gate_n  <= 1'b0;
        end
        FBM_RD_TAKE: begin
          // Array or id query data look alike on the lines
          rsp_valid <= 1'b1;
          rsp_data  <= din_sync_r;
          rsp_bank  <= bank_of(flash_addr);
          rsp_err   <= ~rb_sync_r[1]; // Busy flagged for same-bank care
        end
        FBM_WR_SETUP, FBM_WR_PULSE: begin
          flash_addr     <= pair_rd[PAIR_W-1 -: fbm_pkg::ADDR_W];
          data_lines_out <= pair_rd[fbm_pkg::DATA_W-1:0];
          data_lines_oe  <= 1'b1;
          flash_sel_n    <= 1'b0;
          // Strobe low only with gate high
          wr_strobe_n    <= (state_r == FBM_WR_SETUP);
        end
        FBM_WR_GAP: begin
          // Hold select and data past the strobe rise, so the latch on
          // the rising strobe never races the select edge
          flash_sel_n   <= 1'b0;
          data_lines_oe <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// ===== verilog/fbm_pkg.sv
// Purpose: Shared constants for the flash bus mode host controller
// Assumes: core_clk at 25 MHz; pin timing figures are plain defaults
// Notes:   Times are in ns; cycle counts derive from the clock period
package fbm_pkg;
  localparam int CLK_NS           = 40;
  // Timing figures in ns (plain defaults where no figure is given)
  localparam int ACCESS_NS        = 70;   // address_access_time
  localparam int WRITE_PULSE_NS   = 40;   // write strobe low time
  localparam int CLEAR_PULSE_NS   = 500;  // min_clear_pulse
  localparam int RELEASE_READ_NS  = 50;   // read_after_release_time
  localparam int READY_WAIT_NS    = 20000; // longest ready wait
  // Least times round up, at least one cycle
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC   = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLEAR_CYC   = (CLEAR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RELEASE_CYC = (RELEASE_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_CYC   = READY_WAIT_NS / CLK_NS;
  localparam int CNT_W       = 16;
  // Bus widths, bank and sector fields, sequence lengths
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  localparam int BANK_W      = 2;
  localparam int SECT_W      = 10;
  localparam int BANK_LSB    = 20;
  localparam int SECT_LSB    = 12;
  localparam int UNLOCK_LEN  = 4;
  localparam int BYPASS_LEN  = 2;
  // Host request kinds
  typedef enum logic [1:0] {
    FBM_OP_READ, FBM_OP_WRITE, FBM_OP_RESET, FBM_OP_ACCEL
  } fbm_op_e;
endpackage

// ===== verilog/fbm_seq_mem.sv
// Purpose: Small memory holding a command sequence of address/data pairs
// Assumes: One write port, one registered read port
// Notes:   Read data come out of a register
`timescale 1ns/100ps
module fbm_seq_mem #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     clk_en,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write and registered read
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
    end
  end
endmodule
